// ===== pkg/rte_cfg.svh
/*
  Offsets, field positions, reset values and counts of the RF transmit
  encoder and sequencer. Assumes a byte-addressed AXI4-Lite window of 256 bytes.
*/
`ifndef RTE_CFG_SVH
`define RTE_CFG_SVH
// ==========================================================================
// Register byte offsets
`define RTE_ADDR_CODE_CFG 8'h00
`define RTE_ADDR_FW0_LOW 8'h04
`define RTE_ADDR_FW0_HIGH 8'h08
`define RTE_ADDR_FW1_LOW 8'h0c
`define RTE_ADDR_FW1_HIGH 8'h10
`define RTE_ADDR_RF_CTRL_HIGH 8'h14
`define RTE_ADDR_TX_CTRL 8'h18
`define RTE_ADDR_TX_STATUS 8'h1c
`define RTE_ADDR_PAYLOAD_LEN 8'h20
// ==========================================================================
// Field positions
`define RTE_FMT_B2 2
`define RTE_FMT_B1 1
`define RTE_FMT_B0 0
`define RTE_RATE_MSB 7
`define RTE_RATE_LSB 6
`define RTE_HIGH_BAND_BIT 7
`define RTE_FSK_MODE_BIT 0
`define RTE_START_BIT 0
`define RTE_ST_BUSY_BIT 0
`define RTE_ST_DONE_BIT 1
`define RTE_ST_ALARM_BIT 2
`define RTE_ST_LOCK_BIT 3
// ==========================================================================
// Reset values and constants
`define RTE_CODE_CFG_RST 8'h00
`define RTE_FW_LOW_RST 8'h00
`define RTE_FW_HIGH_RST 5'h00
`define RTE_RF_CTRL_RST 8'h00
`define RTE_PAYLOAD_LEN_RST 8'h00
`define RTE_PAYLOAD_BASE 8'h80
`define RTE_DIV_LOW_BAND 6'h1a
`define RTE_DIV_HIGH_BAND 6'h24
`define RTE_XTAL_SETTLE 16'h0040
`define RTE_RESP_OKAY 2'h0
`define RTE_RESP_SLVERR 2'h2
`endif

// ===== pkg/rte_pkg.sv
/*
  Types of the RF transmit encoder and sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rte_pkg;
  // ========================================================================
  // Line codes and sequencer states
  typedef enum logic [2:0] {
    RTE_FMT_MS = 3'h0,
    RTE_FMT_MAN = 3'h1,
    RTE_FMT_PWM = 3'h2,
    RTE_FMT_BP0 = 3'h3,
    RTE_FMT_BP1 = 3'h4,
    RTE_FMT_DBP0 = 3'h5,
    RTE_FMT_DBP1 = 3'h6
  } rte_fmt_t;
  typedef enum logic [4:0] {
    RTE_ST_IDLE = 5'h01,
    RTE_ST_XTAL = 5'h02,
    RTE_ST_SYNTH = 5'h04,
    RTE_ST_SEND = 5'h08,
    RTE_ST_DONE = 5'h10
  } rte_state_t;
endpackage

// ===== pkg/rte_enc_if.sv
/*
  Byte hand-off between sequencer and symbol encoder.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface rte_enc_if;
  logic load;
  logic [7:0] dataByte;
  logic ready;
  logic busy;
  logic line;
  rte_pkg::rte_fmt_t fmt;
  logic [1:0] rate;
  modport ctrl (output load, output dataByte, output fmt, output rate, input ready, input busy, input line);
  modport encoder (input load, input dataByte, input fmt, input rate, output ready, output busy, output line);
endinterface
`default_nettype wire

// ===== core/rte_symbol_encoder.sv
/*
  Symbol encoder: serialises bytes MSB first into one of seven line codes.
  Assumes the sequencer offers the next byte while ready is high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rte_cfg.svh"
module rte_symbol_encoder (
  input wire logic mclk,
  input wire logic rst,
  rte_enc_if.encoder enc
);
  // ========================================================================
  // Slot timing
  logic [7:0] shift_q;
  logic [2:0] bitIdx_q;
  logic [1:0] slot_q;
  logic [2:0] slotCnt_q;
  logic busy_q;
  logic line_q;
  logic slotEnd;
  logic bitEnd;
  logic byteEnd;
  logic [1:0] lastSlot;

  // Slot length equals bit period / 2 (two-slot codes) or / 3 (PWM)
  function automatic logic [2:0] lastCnt(input logic [1:0] rate);
    case (rate)
      2'h0: lastCnt = 3'h1;
      2'h1: lastCnt = 3'h7;
      2'h2: lastCnt = 3'h3;
      default: lastCnt = 3'h0;
    endcase
  endfunction

  // Level of the line at the start of a slot, from bit and present level
  function automatic logic nextLevel(input rte_pkg::rte_fmt_t f, input logic b, input logic [1:0] s,
                                     input logic cur);
    case (f)
      rte_pkg::RTE_FMT_MS: nextLevel = b;
      rte_pkg::RTE_FMT_MAN: nextLevel = (s == 2'h0) ? b : ~b;
      rte_pkg::RTE_FMT_PWM: nextLevel = (s == 2'h0) ? 1'b1 : ((s == 2'h1) ? b : 1'b0);
      rte_pkg::RTE_FMT_BP0: nextLevel = (s == 2'h0) ? ~cur : (b ? cur : ~cur);
      rte_pkg::RTE_FMT_BP1: nextLevel = (s == 2'h0) ? ~cur : (b ? ~cur : cur);
      rte_pkg::RTE_FMT_DBP0: nextLevel = (s == 2'h0) ? (b ? cur : ~cur) : ~cur;
      rte_pkg::RTE_FMT_DBP1: nextLevel = (s == 2'h0) ? (b ? ~cur : cur) : ~cur;
      default: nextLevel = 1'b0;
    endcase
  endfunction

  // Boundaries; ready opens in the last cycle of a byte for a seamless stream
  assign lastSlot = (enc.fmt == rte_pkg::RTE_FMT_PWM) ? 2'h2 : 2'h1;
  assign slotEnd = busy_q && (slotCnt_q == lastCnt(enc.rate));
  assign bitEnd = slotEnd && (slot_q == lastSlot);
  assign byteEnd = bitEnd && (bitIdx_q == 3'h7);
  assign enc.ready = !busy_q || byteEnd;
  assign enc.busy = busy_q;
  assign enc.line = line_q;

  // ========================================================================
  // Shift register, counters and line level
  always_ff @(posedge mclk) begin
    if (rst) begin
      shift_q <= 8'h00;
      bitIdx_q <= 3'h0;
      slot_q <= 2'h0;
      slotCnt_q <= 3'h0;
      busy_q <= 1'b0;
      line_q <= 1'b0;
    end else if (enc.load && enc.ready) begin
      shift_q <= enc.dataByte;
      bitIdx_q <= 3'h0;
      slot_q <= 2'h0;
      slotCnt_q <= 3'h0;
      busy_q <= 1'b1;
      line_q <= nextLevel(enc.fmt, enc.dataByte[7], 2'h0, line_q);
    end else if (byteEnd) begin
      // Line rests low between telegrams so the amplifier stays off in ASK
      busy_q <= 1'b0;
      line_q <= 1'b0;
    end else if (bitEnd) begin
      shift_q <= {shift_q[6:0], 1'b0};
      bitIdx_q <= bitIdx_q + 3'h1;
      slot_q <= 2'h0;
      slotCnt_q <= 3'h0;
      line_q <= nextLevel(enc.fmt, shift_q[6], 2'h0, line_q);
    end else if (slotEnd) begin
      slot_q <= slot_q + 2'h1;
      slotCnt_q <= 3'h0;
      line_q <= nextLevel(enc.fmt, shift_q[7], slot_q + 2'h1, line_q);
    end else if (busy_q) begin
      slotCnt_q <= slotCnt_q + 3'h1;
    end
  end
endmodule // rte_symbol_encoder
`default_nettype wire

// ===== core/rte_tx_top.sv
/*
  RF transmit sequencer with AXI4-Lite registers, RAM fetch, power sequencing,
  synthesizer word selection and amplifier gating around the symbol encoder.
  Assumes a synchronous RAM read port with one cycle of latency on mclk, and a
  lock indication from the analog PLL that is asynchronous to mclk.
*/
// Added by the designer: the AXI4-Lite register port and the register offsets.
// Overview of operation
// - Encoder takes bytes in parallel, line-codes them, shifts bits out serially.
// - Synth and amplifier controls switch in step with the serial stream.
// - Three format bits in the code config register select seven line codes.
// - Rate bits 7:6 set bit period: 4/16/8/2 clocks, PWM 6/24/12/3.
// - ASK takes carrier solely from frequency word zero, high and low bytes.
// - FSK uses word zero for data 0 and word one for data 1.
// - Divisor 26 with high band clear, 36 with it set; 12 MHz reference.
// - Sigma-delta sees low frequency on data low, high frequency on high.
// - In ASK the amplifier follows the serial data bit by bit.
// - In FSK the amplifier turns on after lock and stays on throughout.
// - Lock loss during transmission mutes the amplifier without software.
// - Lock loss raises the lock alarm flag and output.
// - The sequencer reads RAM directly without the CPU.
// - Payload bytes go to the encoder one after another automatically.
// - Sequencer powers crystal, synthesizer and encoder on and off.
`timescale 1ns/1ns
`default_nettype none
`include "rte_cfg.svh"
module rte_tx_top #(
  parameter logic [15:0] XTAL_SETTLE_CYCLES = `RTE_XTAL_SETTLE
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [7:0] ramAddr,
  output logic ramRdEn,
  input wire logic [7:0] ramRdData,
  input wire logic pllLock,
  output logic xtalEnable,
  output logic synthEnable,
  output logic encoderEnable,
  output logic [5:0] synthDivisor,
  output logic [12:0] synthFraction,
  output logic fskData,
  output logic txData,
  output logic paEnable,
  output logic txDone,
  output logic lockAlarm
);
  // ========================================================================
  // Declarations
  rte_enc_if enc ();
  rte_pkg::rte_state_t state_q;
  logic [7:0] codeCfg_q;
  logic [7:0] fw0Low_q;
  logic [4:0] fw0High_q;
  logic [7:0] fw1Low_q;
  logic [4:0] fw1High_q;
  logic [7:0] rfCtrl_q;
  logic [7:0] payloadLen_q;
  logic awHeld_q;
  logic [7:0] awAddr_q;
  logic wHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic doWrite;
  logic wrByte;
  logic [31:0] rdMux;
  logic rdHit;
  logic startReq_q;
  logic lockMeta_q;
  logic lockSync_q;
  logic done_q;
  logic alarm_q;
  logic [15:0] settleCnt_q;
  logic [7:0] remain_q;
  logic [7:0] ramAddr_q;
  logic rdInFlight_q;
  logic pend_q;
  logic [7:0] nextByte_q;
  logic fskMode;
  logic sending;
  logic sendDone;
  logic xtalEnable_q;
  logic synthEnable_q;
  logic encoderEnable_q;
  logic [5:0] synthDivisor_q;
  logic [12:0] synthFraction_q;
  logic fskData_q;
  logic txData_q;
  logic paEnable_q;

  // Mapped register offsets
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == `RTE_ADDR_CODE_CFG) || (a == `RTE_ADDR_FW0_LOW) || (a == `RTE_ADDR_FW0_HIGH) ||
               (a == `RTE_ADDR_FW1_LOW) || (a == `RTE_ADDR_FW1_HIGH) || (a == `RTE_ADDR_RF_CTRL_HIGH) ||
               (a == `RTE_ADDR_TX_CTRL) || (a == `RTE_ADDR_TX_STATUS) || (a == `RTE_ADDR_PAYLOAD_LEN);
  endfunction

  // ========================================================================
  // AXI4-Lite write channel: address and data taken in either order
  assign awready = !awHeld_q && !bvalid_q;
  assign wready = !wHeld_q && !bvalid_q;
  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  assign wrByte = doWrite && wStrb_q[0];
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RTE_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= isMapped(awAddr_q) ? `RTE_RESP_OKAY : `RTE_RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read channel: one cycle from address to data
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // Read mux; status shows live sequencer state and sticky flags
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    if (araddr == `RTE_ADDR_CODE_CFG) begin
      rdMux[7:0] = codeCfg_q;
    end else if (araddr == `RTE_ADDR_FW0_LOW) begin
      rdMux[7:0] = fw0Low_q;
    end else if (araddr == `RTE_ADDR_FW0_HIGH) begin
      rdMux[4:0] = fw0High_q;
    end else if (araddr == `RTE_ADDR_FW1_LOW) begin
      rdMux[7:0] = fw1Low_q;
    end else if (araddr == `RTE_ADDR_FW1_HIGH) begin
      rdMux[4:0] = fw1High_q;
    end else if (araddr == `RTE_ADDR_RF_CTRL_HIGH) begin
      rdMux[7:0] = rfCtrl_q;
    end else if (araddr == `RTE_ADDR_TX_CTRL) begin
      rdMux[`RTE_START_BIT] = startReq_q;
    end else if (araddr == `RTE_ADDR_TX_STATUS) begin
      rdMux[`RTE_ST_BUSY_BIT] = (state_q != rte_pkg::RTE_ST_IDLE);
      rdMux[`RTE_ST_DONE_BIT] = done_q;
      rdMux[`RTE_ST_ALARM_BIT] = alarm_q;
      rdMux[`RTE_ST_LOCK_BIT] = lockSync_q;
    end else if (araddr == `RTE_ADDR_PAYLOAD_LEN) begin
      rdMux[7:0] = payloadLen_q;
    end else begin
      rdHit = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RTE_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdMux;
      rresp_q <= rdHit ? `RTE_RESP_OKAY : `RTE_RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ========================================================================
  // Configuration registers; software must fill frequency words before start
  always_ff @(posedge mclk) begin
    if (rst) begin
      codeCfg_q <= `RTE_CODE_CFG_RST;
      fw0Low_q <= `RTE_FW_LOW_RST;
      fw0High_q <= `RTE_FW_HIGH_RST;
      fw1Low_q <= `RTE_FW_LOW_RST;
      fw1High_q <= `RTE_FW_HIGH_RST;
      rfCtrl_q <= `RTE_RF_CTRL_RST;
      payloadLen_q <= `RTE_PAYLOAD_LEN_RST;
    end else if (wrByte) begin
      if (awAddr_q == `RTE_ADDR_CODE_CFG) begin
        codeCfg_q <= wData_q[7:0];
      end else if (awAddr_q == `RTE_ADDR_FW0_LOW) begin
        fw0Low_q <= wData_q[7:0];
      end else if (awAddr_q == `RTE_ADDR_FW0_HIGH) begin
        fw0High_q <= wData_q[4:0];
      end else if (awAddr_q == `RTE_ADDR_FW1_LOW) begin
        fw1Low_q <= wData_q[7:0];
      end else if (awAddr_q == `RTE_ADDR_FW1_HIGH) begin
        fw1High_q <= wData_q[4:0];
      end else if (awAddr_q == `RTE_ADDR_RF_CTRL_HIGH) begin
        rfCtrl_q <= wData_q[7:0];
      end else if (awAddr_q == `RTE_ADDR_PAYLOAD_LEN) begin
        payloadLen_q <= wData_q[7:0];
      end
    end
  end

  // Start request: only honoured while idle, cleared as the sequencer leaves
  always_ff @(posedge mclk) begin
    if (rst) begin
      startReq_q <= 1'b0;
    end else if (wrByte && (awAddr_q == `RTE_ADDR_TX_CTRL) && wData_q[`RTE_START_BIT] &&
                 (state_q == rte_pkg::RTE_ST_IDLE)) begin
      startReq_q <= 1'b1;
    end else if (state_q != rte_pkg::RTE_ST_IDLE) begin
      startReq_q <= 1'b0;
    end
  end

  // Sticky flags: a hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      done_q <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      if (state_q == rte_pkg::RTE_ST_DONE) begin
        done_q <= 1'b1;
      end else if (wrByte && (awAddr_q == `RTE_ADDR_TX_STATUS) && wData_q[`RTE_ST_DONE_BIT]) begin
        done_q <= 1'b0;
      end
      if (sending && !lockSync_q) begin
        alarm_q <= 1'b1;
      end else if (wrByte && (awAddr_q == `RTE_ADDR_TX_STATUS) && wData_q[`RTE_ST_ALARM_BIT]) begin
        alarm_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Lock indication crosses from the analog side through two flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      lockMeta_q <= 1'b0;
      lockSync_q <= 1'b0;
    end else begin
      lockMeta_q <= pllLock;
      lockSync_q <= lockMeta_q;
    end
  end

  // ========================================================================
  // Sequencer: crystal settle, synth lock, stream, done
  assign sending = (state_q == rte_pkg::RTE_ST_SEND);
  assign sendDone = (remain_q == 8'h00) && !rdInFlight_q && !pend_q && !enc.busy;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= rte_pkg::RTE_ST_IDLE;
      settleCnt_q <= 16'h0000;
    end else begin
      case (state_q)
        rte_pkg::RTE_ST_IDLE: begin
          settleCnt_q <= 16'h0000;
          if (startReq_q) begin
            state_q <= rte_pkg::RTE_ST_XTAL;
          end
        end
        rte_pkg::RTE_ST_XTAL: begin
          settleCnt_q <= settleCnt_q + 16'h0001;
          if (settleCnt_q >= XTAL_SETTLE_CYCLES - 16'h0001) begin
            state_q <= rte_pkg::RTE_ST_SYNTH;
          end
        end
        rte_pkg::RTE_ST_SYNTH: begin
          if (lockSync_q) begin
            state_q <= rte_pkg::RTE_ST_SEND;
          end
        end
        rte_pkg::RTE_ST_SEND: begin
          if (!lockSync_q) begin
            state_q <= rte_pkg::RTE_ST_IDLE;
          end else if (sendDone) begin
            state_q <= rte_pkg::RTE_ST_DONE;
          end
        end
        default: begin
          state_q <= rte_pkg::RTE_ST_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // RAM fetch: one byte prefetched ahead of the encoder
  assign ramRdEn = sending && !pend_q && !rdInFlight_q && (remain_q != 8'h00);
  assign ramAddr = ramAddr_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      remain_q <= 8'h00;
      ramAddr_q <= `RTE_PAYLOAD_BASE;
      rdInFlight_q <= 1'b0;
      pend_q <= 1'b0;
      nextByte_q <= 8'h00;
    end else if (!sending) begin
      remain_q <= payloadLen_q;
      ramAddr_q <= `RTE_PAYLOAD_BASE;
      rdInFlight_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      rdInFlight_q <= ramRdEn;
      if (ramRdEn) begin
        remain_q <= remain_q - 8'h01;
        ramAddr_q <= ramAddr_q + 8'h01;
      end
      if (rdInFlight_q) begin
        nextByte_q <= ramRdData;
        pend_q <= 1'b1;
      end else if (enc.load && enc.ready) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Encoder hook-up; code bits are read as {b2, b0, b1}
  assign enc.load = sending && pend_q && lockSync_q;
  assign enc.dataByte = nextByte_q;
  assign enc.rate = codeCfg_q[`RTE_RATE_MSB:`RTE_RATE_LSB];
  always_comb begin
    case ({codeCfg_q[`RTE_FMT_B2], codeCfg_q[`RTE_FMT_B0], codeCfg_q[`RTE_FMT_B1]})
      3'h0: enc.fmt = rte_pkg::RTE_FMT_MAN;
      3'h1: enc.fmt = rte_pkg::RTE_FMT_PWM;
      3'h2: enc.fmt = rte_pkg::RTE_FMT_BP0;
      3'h3: enc.fmt = rte_pkg::RTE_FMT_BP1;
      3'h6: enc.fmt = rte_pkg::RTE_FMT_DBP0;
      3'h7: enc.fmt = rte_pkg::RTE_FMT_DBP1;
      default: enc.fmt = rte_pkg::RTE_FMT_MS;
    endcase
  end

  rte_symbol_encoder u_encoder (
    .mclk(mclk),
    .rst(rst),
    .enc(enc)
  );

  // ========================================================================
  // Analog controls, all registered one cycle behind the state, the line or the registers
  assign fskMode = rfCtrl_q[`RTE_FSK_MODE_BIT];

  always_ff @(posedge mclk) begin
    if (rst) begin
      xtalEnable_q <= 1'b0;
      synthEnable_q <= 1'b0;
      encoderEnable_q <= 1'b0;
      synthDivisor_q <= `RTE_DIV_LOW_BAND;
      synthFraction_q <= 13'h0000;
      fskData_q <= 1'b0;
      txData_q <= 1'b0;
      paEnable_q <= 1'b0;
    end else begin
      xtalEnable_q <= (state_q != rte_pkg::RTE_ST_IDLE) && (state_q != rte_pkg::RTE_ST_DONE);
      synthEnable_q <= (state_q == rte_pkg::RTE_ST_SYNTH) || sending;
      encoderEnable_q <= (state_q == rte_pkg::RTE_ST_SYNTH) || sending;
      synthDivisor_q <= rfCtrl_q[`RTE_HIGH_BAND_BIT] ? `RTE_DIV_HIGH_BAND : `RTE_DIV_LOW_BAND;
      // ASK uses word zero only; FSK picks word by data level
      if (fskMode && enc.line) begin
        synthFraction_q <= {fw1High_q, fw1Low_q};
      end else begin
        synthFraction_q <= {fw0High_q, fw0Low_q};
      end
      fskData_q <= fskMode && enc.line;
      txData_q <= sending && enc.line;
      // Lock loss drops the amplifier at once, on the same edge as the state leaves SEND
      if (!sending || !lockSync_q) begin
        paEnable_q <= 1'b0;
      end else if (fskMode) begin
        paEnable_q <= 1'b1;
      end else begin
        paEnable_q <= enc.line;
      end
    end
  end

  assign xtalEnable = xtalEnable_q;
  assign synthEnable = synthEnable_q;
  assign encoderEnable = encoderEnable_q;
  assign synthDivisor = synthDivisor_q;
  assign synthFraction = synthFraction_q;
  assign fskData = fskData_q;
  assign txData = txData_q;
  assign paEnable = paEnable_q;
  assign txDone = done_q;
  assign lockAlarm = alarm_q;
endmodule // rte_tx_top
`default_nettype wire

// ===== testbench/rte_far_model.sv
/* Far-side model: payload RAM read port and analog PLL lock.
   Assumes the mclk domain; lock follows synthEnable after a short settle. */
`timescale 1ns/1ns
`default_nettype none
module rte_far_model (
  input wire logic mclk,
  input wire logic [7:0] ramAddr,
  input wire logic ramRdEn,
  output logic [7:0] ramRdData,
  input wire logic synthEnable,
  input wire logic lockKill,
  output logic pllLock
);
  // ========================================
  // Storage and lock
  logic [7:0] mem [256];
  logic [3:0] settleQ;
  // One cycle latency; idle data churns so a stale byte never looks valid
  always_ff @(posedge mclk) begin
    ramRdData <= ramRdEn ? mem[ramAddr] : ~ramRdData;
  end
  // Lock after settling, lost when killed or powered down
  always_ff @(posedge mclk) begin
    settleQ <= synthEnable ? settleQ + {3'h0, settleQ != 4'hf} : 4'h0;
    pllLock <= synthEnable && settleQ == 4'hf && !lockKill;
  end
endmodule // rte_far_model
`default_nettype wire

// ===== testbench/rte_tx_properties.sv
/* Port checker for rte_tx_top, bound at the foot.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module rte_tx_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ramRdEn,
  input wire logic [7:0] ramAddr,
  input wire logic pllLock,
  input wire logic xtalEnable,
  input wire logic synthEnable,
  input wire logic encoderEnable,
  input wire logic [5:0] synthDivisor,
  input wire logic txData,
  input wire logic paEnable,
  input wire logic txDone,
  input wire logic lockAlarm
);
  // ========================================
  // Shared timing
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence lockDrop;
    $fell(pllLock) && paEnable;
  endsequence
  sequence pathOff;
    !xtalEnable && !synthEnable && !encoderEnable;
  endsequence
  // ========================================
  // Properties
  div_choice_a: assert property (synthDivisor == 6'h1a || synthDivisor == 6'h24)
    else $error("divisor not 26 or 36");
  done_off_a: assert property ($rose(txDone) |-> ##[0:2] pathOff)
    else $error("path powered after done");
  ram_base_a: assert property (ramRdEn |-> ramAddr[7])
    else $error("fetch below payload base");
  ram_send_a: assert property (ramRdEn |-> xtalEnable && synthEnable && encoderEnable)
    else $error("fetch with path unpowered");
  pa_synth_a: assert property (paEnable |-> synthEnable)
    else $error("amplifier on without synthesizer");
  line_idle_a: assert property (!encoderEnable [*3] |-> !txData)
    else $error("line active with encoder off");
  lock_mute_a: assert property (lockDrop |-> ##[1:4] !paEnable)
    else $error("amplifier not muted on lock loss");
  lock_alarm_a: assert property (lockDrop |-> ##[1:4] lockAlarm)
    else $error("no alarm on lock loss");
endmodule // rte_tx_properties
bind rte_tx_top rte_tx_properties rte_tx_properties_inst (.mclk, .rst, .ramRdEn, .ramAddr, .pllLock,
  .xtalEnable, .synthEnable, .encoderEnable, .synthDivisor, .txData, .paEnable, .txDone, .lockAlarm);
`default_nettype wire

// ===== testbench/tb.sv
/* Self-checking bench: AXI4-Lite tasks, telegram runs, lock-loss abort.
   Assumes rte_far_model as RAM and PLL, and a short crystal settle. */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, ramAddr, ramRdData;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic ramRdEn, pllLock, xtalEnable, synthEnable, encoderEnable, fskData, txData, paEnable, txDone, lockAlarm;
  logic lockKill;
  logic [5:0] synthDivisor;
  logic [12:0] synthFraction;
  logic [12:0] fw0 = 13'h0123;
  logic [12:0] fw1 = 13'h1f45;
  int n_mismatch = 0;
  int checks = 0;
  int sp[4] = '{4, 16, 8, 2};
  rte_tx_top #(.XTAL_SETTLE_CYCLES(16'h0004)) rte_tx_top_inst (.mclk, .rst, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .ramAddr, .ramRdEn, .ramRdData, .pllLock, .xtalEnable, .synthEnable, .encoderEnable,
    .synthDivisor, .synthFraction, .fskData, .txData, .paEnable, .txDone, .lockAlarm);
  rte_far_model rte_far_model_inst (.mclk, .ramAddr, .ramRdEn, .ramRdData, .synthEnable, .lockKill, .pllLock);
  // 50 MHz clock
  always #10 mclk = ~mclk;
  // ========================================
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ta, tw, tr;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(negedge mclk);
      {ta, tw, tr, r} = {awvalid && awready, wvalid && wready, bvalid, bresp};
      @(posedge mclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tr) bready <= 1'h0;
    end while (!tr);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge mclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(negedge mclk);
      {ta, tr, d, r} = {arvalid && arready, rvalid, rdata, rresp};
      @(posedge mclk);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
    end while (!tr);
  endtask
  // One telegram; line history decodes bit order when s is set
  task automatic run(input logic [7:0] cfg, input logic [7:0] rf, input int s);
    logic q[$];
    logic [7:0] b;
    logic prev = 1'h0;
    int hi = 0, pa = 0, rises = 0, f = 0;
    wr(8'h00, cfg);
    wr(8'h14, rf);
    wr(8'h20, rf[0] ? 8'h02 : 8'h01);
    wr(8'h18, 8'h01);
    repeat (3000) begin
      @(negedge mclk);
      if (txDone) break;
      q.push_back(txData);
      hi += txData;
      pa += paEnable;
      rises += paEnable && !prev;
      prev = paEnable;
      if (paEnable) chk({synthDivisor, synthFraction},
        {rf[7] ? 6'h24 : 6'h1a, rf[0] && txData ? fw1 : fw0});
      chk(fskData, rf[0] && txData);
    end
    chk(txDone, 1'h1);
    if (rf[0]) chk(rises, 1);
    else chk(pa, hi);
    if (!rf[0]) chk(hi, s ? 4 * s : cfg[2:0] == 2 ? 12 : 8);
    while (s > 0 && f < q.size() && !q[f]) f++;
    for (int k = 0; k < 8; k++) b[7-k] = q[f + k * s];
    if (s > 0) chk(b, 8'ha5);
    rd(8'h1c);
    chk(d[2:0], 3'h2);
    wr(8'h1c, 8'h02);
    $display("telegram cfg=%h rf=%h done", cfg, rf);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog far above the thousand-odd cycles needed
  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    report_and_stop;
  end
  // ========================================
  // Test sequence
  initial begin
    {mclk, rst, awvalid, wvalid, bready, arvalid, rready, lockKill} = 8'h40;
    {awaddr, araddr, wdata, wstrb} = 52'h0000_0000_0000_f;
    rte_far_model_inst.mem[8'h80] = 8'ha5;
    rte_far_model_inst.mem[8'h81] = 8'h3c;
    repeat (5) @(posedge mclk);
    rst <= 1'h0;
    rd(8'h00);
    chk(d, 8'h00);
    rd(8'h40);
    chk(d, 0);
    chk(r, 2'h2);
    wr(8'h44, 8'h01);
    chk(r, 2'h2);
    wr(8'h04, 8'h23);
    wr(8'h08, 8'h01);
    wr(8'h0c, 8'h45);
    wr(8'h10, 8'hff);
    rd(8'h10);
    chk(d, 8'h1f);
    $display("registers done");
    for (int c = 0; c < 8; c++) run({5'h18, c[2:0]}, 8'h00, 0);
    for (int k = 0; k < 4; k++) run({k[1:0], 6'h04}, 8'h00, sp[k]);
    run(8'hc1, 8'h81, 0);
    wr(8'h18, 8'h01);
    repeat (300) begin
      @(negedge mclk);
      if (paEnable) break;
    end
    @(posedge mclk);
    lockKill <= 1'h1;
    repeat (6) @(negedge mclk);
    chk({paEnable, lockAlarm, txDone}, 3'h2);
    lockKill <= 1'h0;
    rd(8'h1c);
    chk(d[2:0], 3'h4);
    wr(8'h1c, 8'h04);
    rd(8'h1c);
    chk(d[2:0], 3'h0);
    $display("lock loss done");
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
